// file: core/cycle_acct_pkg.sv
/*
  package for the pipeline cycle accounting block: widths, timing constants
  and the packed structs that carry instruction timing descriptors and costs.
  assumes a single clock domain; the checker and the bench use it as well as the accounting core.
*/
package cycle_acct_pkg;

  // ---------------------------------------------------------------------
  // widths
  // ---------------------------------------------------------------------
  localparam int unsigned CYC_W = 16;
  localparam int unsigned K_W   = 8;

  // ---------------------------------------------------------------------
  // per-instruction figures
  // ---------------------------------------------------------------------
  localparam logic [CYC_W-1:0] ACB_EXEC_CYC       = 16'h0005;
  localparam logic signed [K_W-1:0] ACB_BREAK_K   = 8'sh01;
  localparam logic [CYC_W-1:0] CHECK_EXEC_CYC     = 16'h000A;
  localparam logic signed [K_W-1:0] CHECK_BREAK_K = -8'sh03;
  localparam logic [CYC_W-1:0] BCOND_EXEC_CYC     = 16'h0002;
  localparam logic signed [K_W-1:0] BCOND_BREAK_K = 8'sh02;
  localparam logic [CYC_W-1:0] RET_EXTRA_CYC      = 16'h0004;
  localparam logic [CYC_W-1:0] REG_MOVE_CYC       = 16'h0002;
  localparam logic [CYC_W-1:0] WB_FIRST_MIN_CYC   = 16'h0006;
  localparam logic [CYC_W-1:0] WB_FIRST_MAX_CYC   = 16'h0007;
  localparam logic [CYC_W-1:0] WB_SECOND_CYC      = 16'h0002;

  // ---------------------------------------------------------------------
  // reset values of the previous-instruction history
  // ---------------------------------------------------------------------
  localparam logic [CYC_W-1:0]      PREV_EXEC_RST  = 16'h0000;
  localparam logic [CYC_W-1:0]      PREV_FLOAT_RST = 16'h0000;
  localparam logic signed [K_W-1:0] PREV_K_RST     = 8'sh00;

  // ---------------------------------------------------------------------
  // types
  // ---------------------------------------------------------------------
  typedef enum logic [2:0] {
    INSTR_GENERIC,
    INSTR_ADD_COMPARE_BRANCH,
    INSTR_BOUNDS_CHECK,
    INSTR_COND_BRANCH,
    INSTR_RETURN,
    INSTR_FLOAT
  } instr_class_t;

  typedef struct packed {
    instr_class_t     iclass;
    logic [CYC_W-1:0] exec_unit_cycles;
    logic [CYC_W-1:0] addr_unit_cycles;
    logic             has_break;
    logic signed [K_W-1:0] break_k;
    logic             mispredicted;
    logic             branch_taken;
    logic             out_of_bounds;
    logic             overflow_trap_en;
    logic [CYC_W-1:0] trap_cycles;
    logic [CYC_W-1:0] slave_transfer_cycles;
    logic [CYC_W-1:0] slave_completion_cycles;
    logic [CYC_W-1:0] float_unit_cycles;
    logic             wait_writes;
    logic             wb_first_slow;
    logic             wb_second;
    logic [CYC_W-1:0] dependency_delay;
    logic [CYC_W-1:0] storage_delay;
  } instr_desc_t;

  typedef struct packed {
    logic [CYC_W-1:0]      hidden_gap;
    logic [CYC_W-1:0]      float_overhead_cycles;
    logic [CYC_W-1:0]      pipeline_exec_cycles;
    logic [CYC_W-1:0]      effective_cycles;
    logic signed [K_W-1:0] break_k;
    logic                  has_break;
  } instr_cost_t;

endpackage : cycle_acct_pkg

// file: core/pipeline_cycle_accounting.sv
/*
  pipeline cycle accounting core: for every instruction descriptor presented
  with a valid strobe it computes the cycles the instruction costs in a
  four-stage pipeline and remembers the instruction as the predecessor of
  the next one.
  assumes descriptors come from logic on sys_clk_i; no crossing is needed.
*/
module pipeline_cycle_accounting (
  // clock and reset
  input  wire logic                          sys_clk_i,
  input  wire logic                          resetn_i,
  // instruction descriptor in
  input  wire logic                          instr_valid_i,
  input  wire cycle_acct_pkg::instr_desc_t   instr_i,
  // cost out
  output logic                               cost_valid_o,
  output cycle_acct_pkg::instr_cost_t        cost_o,
  output logic [cycle_acct_pkg::CYC_W-1:0]   total_cycles_o
);

  localparam int unsigned CW = cycle_acct_pkg::CYC_W;
  localparam int unsigned KW = cycle_acct_pkg::K_W;
  // the gap arithmetic carries the address time, a carry bit and a sign bit
  localparam int unsigned GW = CW + 2;

  // ---------------------------------------------------------------------
  // elaboration checks
  // ---------------------------------------------------------------------
  // the break value is sign-extended into the gap arithmetic, never cut
  if (KW > GW) begin : g_k_too_wide
    $error("break value wider than the gap arithmetic");
  end
  // the fixed break values run from -3 to 2: a sign bit and two more
  if (KW < 3) begin : g_k_too_narrow
    $error("break value too narrow for the fixed break values");
  end
  // the widest fixed execution time is the bounds check
  if (CW < 4) begin : g_cycles_too_narrow
    $error("cycle count too narrow for the fixed execution times");
  end
  // the break-value and execution history is cleared to values of exactly its own widths
  if ($bits(cycle_acct_pkg::PREV_K_RST) != KW
      || $bits(cycle_acct_pkg::PREV_EXEC_RST) != CW) begin : g_reset_width
    $error("history reset values do not match the history widths");
  end
  // a slow first write-buffer operand never costs less than a fast one
  if (cycle_acct_pkg::WB_FIRST_MIN_CYC > cycle_acct_pkg::WB_FIRST_MAX_CYC) begin : g_wb_order
    $error("write-buffer figures out of order");
  end

  // ---------------------------------------------------------------------
  // history of the previous instruction
  // ---------------------------------------------------------------------
  logic [CW-1:0]        prev_exec_q;
  logic [CW-1:0]        prev_float_q;
  logic signed [KW-1:0] prev_k_q;
  logic                 prev_break_q;
  logic                 prev_return_q;

  // ---------------------------------------------------------------------
  // combinational evaluation
  // ---------------------------------------------------------------------
  logic [CW-1:0]        exec_d;
  logic [CW-1:0]        float_d;
  logic [CW-1:0]        gap_d;
  logic [CW-1:0]        pipe_d;
  logic [CW-1:0]        eff_d;
  logic [CW-1:0]        wb_d;
  logic signed [KW-1:0] k_d;
  logic                 brk_d;
  // per-concern terms
  logic [CW-1:0]        trap_d;
  logic [CW-1:0]        ret_d;
  logic [CW-1:0]        wb_first_d;
  logic [CW-1:0]        wb_second_d;
  logic                 is_float_d;
  logic                 is_return_d;

  // exposed address-unit time given the predecessor
  function automatic logic [CW-1:0] unhidden(
    input logic [CW-1:0]        au,
    input logic [CW-1:0]        pexec,
    input logic [CW-1:0]        pflt,
    input logic                 pbrk,
    input logic signed [KW-1:0] pk
  );
    logic signed [GW-1:0] sum;
    // k is sign-extended so that a negative break shortens the exposed time
    sum = $signed({2'b00, au}) + GW'(pk);
    if (pbrk) begin
      // positive k holds the address unit, negative starts it early
      unhidden = (sum > 0) ? sum[CW-1:0] : '0;
    end else if ({1'b0, au} <= ({1'b0, pexec} + {1'b0, pflt})) begin
      unhidden = '0;
    end else begin
      unhidden = au - pexec;
    end
  endfunction : unhidden

  // ---------------------------------------------------------------------
  // class decode
  // ---------------------------------------------------------------------
  // class flags shared by the float and history concerns
  always_comb begin
    is_float_d  = (instr_i.iclass == cycle_acct_pkg::INSTR_FLOAT);
    is_return_d = (instr_i.iclass == cycle_acct_pkg::INSTR_RETURN);
  end

  // trap handling time, only for a bounds check whose trap is taken
  always_comb begin
    trap_d = '0;
    if (instr_i.iclass == cycle_acct_pkg::INSTR_BOUNDS_CHECK
        && instr_i.out_of_bounds && instr_i.overflow_trap_en) begin
      trap_d = instr_i.trap_cycles;
    end
  end

  // execution-unit time: fixed for the two branch classes, fixed plus any taken trap time for the bounds check
  always_comb begin
    exec_d = instr_i.exec_unit_cycles;
    unique case (instr_i.iclass)
      cycle_acct_pkg::INSTR_GENERIC: begin
        exec_d = instr_i.exec_unit_cycles;
      end
      cycle_acct_pkg::INSTR_ADD_COMPARE_BRANCH: begin
        exec_d = cycle_acct_pkg::ACB_EXEC_CYC;
      end
      cycle_acct_pkg::INSTR_BOUNDS_CHECK: begin
        exec_d = CW'(cycle_acct_pkg::CHECK_EXEC_CYC + trap_d);
      end
      cycle_acct_pkg::INSTR_COND_BRANCH: begin
        exec_d = cycle_acct_pkg::BCOND_EXEC_CYC;
      end
      cycle_acct_pkg::INSTR_RETURN: begin
        exec_d = instr_i.exec_unit_cycles;
      end
      cycle_acct_pkg::INSTR_FLOAT: begin
        exec_d = instr_i.exec_unit_cycles;
      end
      default: begin
        // codes past the last class cost what the descriptor says
        exec_d = instr_i.exec_unit_cycles;
      end
    endcase
  end

  // break status: forced for the branch-like classes
  always_comb begin
    brk_d = instr_i.has_break;
    k_d   = instr_i.break_k;
    unique case (instr_i.iclass)
      cycle_acct_pkg::INSTR_ADD_COMPARE_BRANCH: begin
        brk_d = instr_i.mispredicted;
        k_d   = cycle_acct_pkg::ACB_BREAK_K;
      end
      cycle_acct_pkg::INSTR_BOUNDS_CHECK: begin
        brk_d = 1'b1;
        k_d   = cycle_acct_pkg::CHECK_BREAK_K;
      end
      cycle_acct_pkg::INSTR_COND_BRANCH: begin
        // only a taken branch redirects the address unit
        brk_d = instr_i.branch_taken;
        k_d   = cycle_acct_pkg::BCOND_BREAK_K;
      end
      cycle_acct_pkg::INSTR_GENERIC,
      cycle_acct_pkg::INSTR_RETURN,
      cycle_acct_pkg::INSTR_FLOAT: begin
        brk_d = instr_i.has_break;
        k_d   = instr_i.break_k;
      end
      default: begin
        brk_d = instr_i.has_break;
        k_d   = instr_i.break_k;
      end
    endcase
  end

  // write-buffer stall: first pending operand, then any second one
  always_comb begin
    wb_first_d  = '0;
    wb_second_d = '0;
    if (instr_i.wait_writes) begin
      wb_first_d = instr_i.wb_first_slow ? cycle_acct_pkg::WB_FIRST_MAX_CYC
                                         : cycle_acct_pkg::WB_FIRST_MIN_CYC;
      if (instr_i.wb_second) begin
        wb_second_d = cycle_acct_pkg::WB_SECOND_CYC;
      end
    end
  end

  // the stall is one term of the pipeline time
  always_comb begin
    wb_d = CW'(wb_first_d + wb_second_d);
  end

  always_comb begin
    float_d = '0;
    if (is_float_d) begin
      // processor-side terms plus the externally supplied unit time
      float_d = CW'(instr_i.slave_transfer_cycles + instr_i.slave_completion_cycles
                    + instr_i.float_unit_cycles);
    end
  end

  // the return itself is costed from its descriptor; its flush is paid by the next one
  always_comb begin
    ret_d = '0;
    if (prev_return_q) begin
      ret_d = cycle_acct_pkg::RET_EXTRA_CYC;
    end
  end

  // every sum wraps at the cycle width
  always_comb begin
    gap_d = unhidden(instr_i.addr_unit_cycles, prev_exec_q, prev_float_q,
                     prev_break_q, prev_k_q);
    pipe_d = CW'(gap_d + exec_d + float_d + wb_d + ret_d);
    eff_d = CW'(pipe_d + instr_i.dependency_delay + instr_i.storage_delay);
  end

  // ---------------------------------------------------------------------
  // history update
  // ---------------------------------------------------------------------
  // execution and float time of the predecessor; idle cycles leave it untouched
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      prev_exec_q  <= cycle_acct_pkg::PREV_EXEC_RST;
      prev_float_q <= cycle_acct_pkg::PREV_FLOAT_RST;
    end else if (instr_valid_i) begin
      prev_exec_q  <= exec_d;
      prev_float_q <= float_d;
    end
  end

  // break status of the predecessor
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      prev_k_q     <= cycle_acct_pkg::PREV_K_RST;
      prev_break_q <= 1'b0;
    end else if (instr_valid_i) begin
      prev_k_q     <= k_d;
      prev_break_q <= brk_d;
    end
  end

  // whether the predecessor was a return
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      prev_return_q <= 1'b0;
    end else if (instr_valid_i) begin
      prev_return_q <= is_return_d;
    end
  end

  // ---------------------------------------------------------------------
  // registered outputs
  // ---------------------------------------------------------------------
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      cost_valid_o <= 1'b0;
    end else begin
      cost_valid_o <= instr_valid_i;
    end
  end

  // the cost stands until the next accepted instruction
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      cost_o <= '0;
    end else if (instr_valid_i) begin
      cost_o.hidden_gap            <= gap_d;
      cost_o.float_overhead_cycles <= float_d;
      cost_o.pipeline_exec_cycles  <= pipe_d;
      cost_o.effective_cycles      <= eff_d;
      cost_o.break_k               <= k_d;
      cost_o.has_break             <= brk_d;
    end
  end

  // running sum of effective time, wrapping at the cycle width
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      total_cycles_o <= '0;
    end else if (instr_valid_i) begin
      total_cycles_o <= CW'(total_cycles_o + eff_d);
    end
  end

endmodule : pipeline_cycle_accounting

// file: verification/cycle_acct_sva.sv
/*
  checker for the cycle accounting core.
  assumes only the top module's ports and one clock domain.
*/
module cycle_acct_sva (
  // clock and reset
  input wire logic                                 sys_clk_i,
  input wire logic                                 resetn_i,
  // descriptor in
  input wire logic                                 instr_valid_i,
  input wire cycle_acct_pkg::instr_desc_t          instr_i,
  // cost out
  input wire logic                                 cost_valid_o,
  input wire cycle_acct_pkg::instr_cost_t          cost_o,
  input wire logic [cycle_acct_pkg::CYC_W-1:0]     total_cycles_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!resetn_i);
  property p_answer; instr_valid_i |=> cost_valid_o; endproperty
  a_answer: assert property (p_answer) else $error("cost missing");
  property p_idle; !instr_valid_i |=> !cost_valid_o && $stable(cost_o); endproperty
  a_idle: assert property (p_idle) else $error("idle cycle changed cost");
  property p_total;
    cost_valid_o |-> total_cycles_o == 16'($past(total_cycles_o) + cost_o.effective_cycles);
  endproperty
  a_total: assert property (p_total) else $error("total not summed");
  property p_eff;
    instr_valid_i |=> cost_o.effective_cycles == 16'(cost_o.pipeline_exec_cycles
      + $past(instr_i.dependency_delay) + $past(instr_i.storage_delay));
  endproperty
  a_eff: assert property (p_eff) else $error("effective time wrong");
  sequence s_cls(cycle_acct_pkg::instr_class_t c); instr_valid_i && instr_i.iclass == c; endsequence
  property p_acb;
    s_cls(cycle_acct_pkg::INSTR_ADD_COMPARE_BRANCH) |=> cost_o.has_break == $past(instr_i.mispredicted)
      && (!cost_o.has_break || cost_o.break_k == 8'sh01);
  endproperty
  a_acb: assert property (p_acb) else $error("compare branch break wrong");
  property p_chk;
    s_cls(cycle_acct_pkg::INSTR_BOUNDS_CHECK) |=> cost_o.has_break && cost_o.break_k == -8'sh03;
  endproperty
  a_chk: assert property (p_chk) else $error("bounds check break wrong");
  property p_cond;
    s_cls(cycle_acct_pkg::INSTR_COND_BRANCH) |=> cost_o.has_break == $past(instr_i.branch_taken);
  endproperty
  a_cond: assert property (p_cond) else $error("branch break wrong");
  property p_nflt;
    instr_valid_i && instr_i.iclass != cycle_acct_pkg::INSTR_FLOAT
      |=> cost_o.float_overhead_cycles == 16'h0000;
  endproperty
  a_nflt: assert property (p_nflt) else $error("float term not zero");
  property p_flt;
    s_cls(cycle_acct_pkg::INSTR_FLOAT) |=> cost_o.float_overhead_cycles
      == 16'($past(instr_i.slave_transfer_cycles) + $past(instr_i.slave_completion_cycles)
      + $past(instr_i.float_unit_cycles));
  endproperty
  a_flt: assert property (p_flt) else $error("float term wrong");
  c_acb: cover property (s_cls(cycle_acct_pkg::INSTR_ADD_COMPARE_BRANCH) ##1 cost_o.has_break);
  c_flt: cover property (s_cls(cycle_acct_pkg::INSTR_FLOAT));
  c_ret: cover property (s_cls(cycle_acct_pkg::INSTR_RETURN) ##1 instr_valid_i);
endmodule : cycle_acct_sva

bind pipeline_cycle_accounting cycle_acct_sva u_sva (.sys_clk_i(sys_clk_i), .resetn_i(resetn_i),
  .instr_valid_i(instr_valid_i), .instr_i(instr_i), .cost_valid_o(cost_valid_o),
  .cost_o(cost_o), .total_cycles_o(total_cycles_o));

// file: verification/tb_top.sv
/*
  random self-checking bench for the cycle accounting core.
  assumes the core and its package are compiled first.
*/
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic                        sys_clk_i = 1'b0;
  logic                        resetn_i = 1'b0;
  logic                        instr_valid_i = 1'b0;
  cycle_acct_pkg::instr_desc_t instr_i = '0;
  logic                        cost_valid_o;
  cycle_acct_pkg::instr_cost_t cost_o;
  logic [15:0]                 total_cycles_o;
  cycle_acct_pkg::instr_cost_t exp_q[$];
  logic [15:0]                 tot_q[$];
  logic [15:0]                 pe = '0, pf = '0, tot = '0, ex, fl, gap, wb;
  logic                        pb = 1'b0, pr = 1'b0;
  logic signed [7:0]           pk = '0;
  int                          failures = 0;
  int                          cmp_count = 0;
  always #2 sys_clk_i = ~sys_clk_i;
  pipeline_cycle_accounting dut (.sys_clk_i(sys_clk_i), .resetn_i(resetn_i),
    .instr_valid_i(instr_valid_i), .instr_i(instr_i), .cost_valid_o(cost_valid_o),
    .cost_o(cost_o), .total_cycles_o(total_cycles_o));
  // ---------------------------------------------------------------------
  // reference cost of one accepted instruction
  // ---------------------------------------------------------------------
  task automatic model(input cycle_acct_pkg::instr_desc_t d);
    cycle_acct_pkg::instr_cost_t c;
    int s;
    c = '0;
    ex = d.exec_unit_cycles;
    c.has_break = d.has_break;
    c.break_k = d.break_k;
    case (d.iclass)
      cycle_acct_pkg::INSTR_ADD_COMPARE_BRANCH: begin
        ex = 16'h0005;
        c.has_break = d.mispredicted;
        c.break_k = 8'sh01;
      end
      cycle_acct_pkg::INSTR_BOUNDS_CHECK: begin
        ex = 16'h000A + ((d.out_of_bounds && d.overflow_trap_en) ? d.trap_cycles : 16'h0000);
        c.has_break = 1'b1;
        c.break_k = -8'sh03;
      end
      cycle_acct_pkg::INSTR_COND_BRANCH: begin
        ex = 16'h0002;
        c.has_break = d.branch_taken;
        c.break_k = 8'sh02;
      end
      default: ;
    endcase
    fl = 16'h0000;
    if (d.iclass == cycle_acct_pkg::INSTR_FLOAT)
      fl = d.slave_transfer_cycles + d.slave_completion_cycles + d.float_unit_cycles;
    s = int'(d.addr_unit_cycles) + int'(pk);
    if (pb)
      gap = (s > 0) ? 16'(s) : 16'h0000;
    else
      gap = (d.addr_unit_cycles <= pe + pf) ? 16'h0000 : d.addr_unit_cycles - pe;
    wb = d.wait_writes ? ((d.wb_first_slow ? 16'h0007 : 16'h0006)
      + (d.wb_second ? 16'h0002 : 16'h0000)) : 16'h0000;
    c.hidden_gap = gap;
    c.float_overhead_cycles = fl;
    c.pipeline_exec_cycles = gap + ex + fl + wb + (pr ? 16'h0004 : 16'h0000);
    c.effective_cycles = c.pipeline_exec_cycles + d.dependency_delay + d.storage_delay;
    tot = tot + c.effective_cycles;
    pe = ex;
    pf = fl;
    pb = c.has_break;
    pk = c.break_k;
    pr = (d.iclass == cycle_acct_pkg::INSTR_RETURN);
    exp_q.push_back(c);
    tot_q.push_back(tot);
  endtask : model
  task results;
    $display("failures=%0d compares=%0d", failures, cmp_count);
    if (failures == 0 && cmp_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : results
  // ---------------------------------------------------------------------
  // output watcher
  // ---------------------------------------------------------------------
  always @(negedge sys_clk_i) begin
    cycle_acct_pkg::instr_cost_t e;
    logic [15:0] t;
    if (resetn_i && cost_valid_o !== 1'b0) begin
      e = (exp_q.size() > 0) ? exp_q.pop_front() : '1;
      t = (tot_q.size() > 0) ? tot_q.pop_front() : '1;
      cmp_count++;
      if ({cost_o, total_cycles_o} !== {e, t}) begin
        $display("BAD t=%0t got=%h exp=%h", $time, {cost_o, total_cycles_o}, {e, t});
        failures++;
      end
    end
  end
  // ---------------------------------------------------------------------
  // stimulus
  // ---------------------------------------------------------------------
  initial begin
    cycle_acct_pkg::instr_desc_t d;
    void'($urandom(32'h0452));
    repeat (6) @(negedge sys_clk_i);
    resetn_i = 1'b1;
    for (int i = 0; i < 400; i++) begin
      if (i == 200) begin
        // second reset in mid-run: drain, reset, restart the reference history
        @(negedge sys_clk_i);
        instr_valid_i = 1'b0;
        repeat (2) @(negedge sys_clk_i);
        resetn_i = 1'b0;
        repeat (3) @(negedge sys_clk_i);
        {pe, pf, tot, pb, pr, pk} = '0;
        resetn_i = 1'b1;
      end
      @(negedge sys_clk_i);
      d = '0;
      d.iclass = cycle_acct_pkg::instr_class_t'($urandom_range(5));
      d.exec_unit_cycles = 16'($urandom_range(8));
      d.addr_unit_cycles = 16'($urandom_range(20));
      d.has_break = 1'($urandom);
      d.break_k = 8'(signed'($urandom_range(8)) - 4);
      {d.mispredicted, d.branch_taken, d.out_of_bounds, d.overflow_trap_en} = 4'($urandom);
      {d.wait_writes, d.wb_first_slow, d.wb_second} = 3'($urandom);
      d.trap_cycles = 16'($urandom_range(30));
      d.slave_transfer_cycles = 16'($urandom_range(3));
      d.slave_completion_cycles = 16'($urandom_range(3));
      d.float_unit_cycles = 16'($urandom_range(9));
      d.dependency_delay = 16'($urandom_range(3));
      d.storage_delay = 16'($urandom_range(5));
      instr_i = d;
      instr_valid_i = ($urandom_range(3) != 0);
      if (instr_valid_i)
        model(d);
    end
    @(negedge sys_clk_i);
    instr_valid_i = 1'b0;
    repeat (3) @(negedge sys_clk_i);
    if (exp_q.size() != 0) begin
      $display("BAD t=%0t got=%h exp=%h", $time, exp_q.size(), 0);
      failures++;
    end
    results();
  end
  initial begin
    #20000;
    failures++;
    results();
  end
endmodule : tb_top
